// *** rtl/mbw_pkg.sv ***
// Constants, field positions and state type for the multi-register write handler.
// Assumes a byte-wide receiver and transmitter on the same clock as the handler.
// Notes on behaviour
// - Function 10h writes consecutive registers from start.
// - At most sixteen registers per request.
// - Registers are committed in ascending address order.
// - Out-of-map address gives exception; earlier writes stay.
// - Query: address, function, start, count, bytes, data, check.
// - Byte count equals twice the register count.
// - Success reply echoes address, function, start, count.
// - Every frame ends with CRC-16, low byte first.
// - Each 32-bit datum is two 16-bit registers.
// - Even address upper half, odd address lower half.
package mbw_pkg;
  localparam logic [7:0]  FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  EXC_FUNC       = 8'h01;
  localparam logic [7:0]  EXC_ADDR       = 8'h02;
  localparam logic [7:0]  EXC_VALUE      = 8'h03;
  localparam logic [7:0]  BCAST_ADDR     = 8'h00;
  localparam logic [15:0] MAX_REGS       = 16'h0010;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;
  // Byte positions inside the query
  localparam logic [7:0]  POS_SLAVE      = 8'h00;
  localparam logic [7:0]  POS_FUNC       = 8'h01;
  localparam logic [7:0]  POS_START_HI   = 8'h02;
  localparam logic [7:0]  POS_START_LO   = 8'h03;
  localparam logic [7:0]  POS_COUNT_HI   = 8'h04;
  localparam logic [7:0]  POS_COUNT_LO   = 8'h05;
  localparam logic [7:0]  POS_BCOUNT     = 8'h06;
  localparam logic [7:0]  POS_DATA       = 8'h07;
  localparam logic [8:0]  QUERY_OVERHEAD = 9'h009;
  localparam logic [7:0]  POS_LIMIT      = 8'hff;
  // Reply lengths in bytes, check included
  localparam logic [3:0]  ACK_LEN        = 4'h8;
  localparam logic [3:0]  EXC_LEN        = 4'h5;
  typedef enum logic [1:0] {ST_RECV, ST_CHECK, ST_WRITE, ST_REPLY} mbw_state_t;
endpackage

// *** rtl/mbw_mem_if.sv ***
// Carrier between the handler and its memories.
// Assumes one write port with lane enables and one registered read port.
`timescale 1ns/1ps
interface mbw_mem_if #(
  parameter int AW = 4,
  parameter int DW = 16,
  parameter int LN = 1
);
  logic [LN-1:0] we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** rtl/mbw_mem.sv ***
// Small memory with per-lane write enables and a registered read port.
// Assumes DW divides evenly into LN lanes.
`timescale 1ns/1ps
module mbw_mem #(
  parameter int AW = 4,
  parameter int DW = 16,
  parameter int LN = 1
) (
  // Clock
  input wire logic clk_in,
  // Port
  mbw_mem_if.mem   port
);
  localparam int LW = DW / LN;

  ////////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < LN; g++) begin : g_lane
      // Each lane owns its array so no two processes write one variable
      logic [LW-1:0] lane_ff [2**AW];
      logic [LW-1:0] lane_rd_ff;
      always_ff @(posedge clk_in) begin
        if (port.we[g]) begin
          lane_ff[port.waddr] <= port.wdata[g*LW +: LW];
        end
        lane_rd_ff <= lane_ff[port.raddr];
      end
      assign port.rdata[g*LW +: LW] = lane_rd_ff;
    end
  endgenerate
endmodule

// *** rtl/mbw_handler.sv ***
// Slave handler for the write-multiple-registers request and its reply.
// Assumes rx bytes and the end-of-frame pulse come from same-clock receiver logic.
`timescale 1ns/1ps
module mbw_handler #(
  parameter int DATUM_AW = 8
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Configuration
  input  wire logic [7:0]  slave_addr_in,
  // Receive stream
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_valid_in,
  input  wire logic        rx_frame_end_in,
  // Transmit stream
  output logic      [7:0]  tx_byte_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  // Register write notice
  output logic             wr_strobe_out,
  output logic      [15:0] wr_addr_out,
  output logic      [15:0] wr_data_out,
  // Driver datum read
  input  wire logic [DATUM_AW-1:0] drv_index_in,
  output logic      [31:0] drv_data_out
);
  localparam logic [16:0] REG_SPAN = 17'(2 * (2 ** DATUM_AW));

  mbw_pkg::mbw_state_t state_ff;
  logic [7:0]  pos_ff;
  logic [7:0]  slave_ff;
  logic [7:0]  func_ff;
  logic [15:0] start_ff;
  logic [15:0] count_ff;
  logic [7:0]  bcnt_ff;
  logic [7:0]  hi_byte_ff;
  logic [15:0] crc_ff;
  logic [3:0]  idx_ff;
  logic        phase_ff;
  logic [7:0]  exc_ff;
  logic [3:0]  txi_ff;
  logic [15:0] tx_crc_ff;
  logic [7:0]  tx_byte_ff;
  logic        tx_valid_ff;
  logic        wr_strobe_ff;
  logic [15:0] wr_addr_ff;
  logic [15:0] wr_data_ff;

  mbw_mem_if #(.AW(4), .DW(16), .LN(1)) stage ();
  mbw_mem_if #(.AW(DATUM_AW), .DW(32), .LN(2)) store ();

  mbw_mem #(.AW(4), .DW(16), .LN(1)) u_stage (
    .clk_in (clk_in),
    .port   (stage)
  );
  mbw_mem #(.AW(DATUM_AW), .DW(32), .LN(2)) u_store (
    .clk_in (clk_in),
    .port   (store)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mbw_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  wire logic [7:0]  data_off   = pos_ff - mbw_pkg::POS_DATA;
  wire logic        data_byte  = (pos_ff >= mbw_pkg::POS_DATA) && (data_off < 8'h20);
  wire logic        addr_hit   = (slave_ff == slave_addr_in) ||
                                 (slave_ff == mbw_pkg::BCAST_ADDR);
  // Residue of the CRC over the whole frame, check bytes included, is zero
  wire logic        frame_ok   = (crc_ff == 16'h0000) && addr_hit &&
                                 ({1'b0, pos_ff} == mbw_pkg::QUERY_OVERHEAD + {1'b0, bcnt_ff});
  wire logic        count_ok   = (count_ff != 16'h0000) && (count_ff <= mbw_pkg::MAX_REGS) &&
                                 ({8'h00, bcnt_ff} == 16'(count_ff << 1));
  wire logic [15:0] reg_addr   = start_ff + {12'h000, idx_ff};
  wire logic        reg_in_map = {1'b0, reg_addr} < REG_SPAN;
  wire logic        last_reg   = ({12'h000, idx_ff} == count_ff - 16'h0001);
  wire logic        is_exc     = (exc_ff != 8'h00);
  wire logic [3:0]  tx_len     = is_exc ? mbw_pkg::EXC_LEN : mbw_pkg::ACK_LEN;
  wire logic        commit     = (state_ff == mbw_pkg::ST_WRITE) && phase_ff && reg_in_map;

  ////////////////////////////////////////////////////////////////////////////////
  // Query reception
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pos_ff <= 8'h00;
      crc_ff <= mbw_pkg::CRC_INIT;
    end else if (state_ff != mbw_pkg::ST_RECV) begin
      pos_ff <= 8'h00;
      crc_ff <= mbw_pkg::CRC_INIT;
    end else if (rx_valid_in) begin
      // Saturate so an oversized frame can never alias a legal length
      pos_ff <= (pos_ff == mbw_pkg::POS_LIMIT) ? pos_ff : pos_ff + 8'h01;
      crc_ff <= crc_step(crc_ff, rx_byte_in);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      slave_ff   <= 8'h00;
      func_ff    <= 8'h00;
      start_ff   <= 16'h0000;
      count_ff   <= 16'h0000;
      bcnt_ff    <= 8'h00;
      hi_byte_ff <= 8'h00;
    end else if ((state_ff == mbw_pkg::ST_RECV) && rx_valid_in) begin
      case (pos_ff)
        mbw_pkg::POS_SLAVE:    slave_ff        <= rx_byte_in;
        mbw_pkg::POS_FUNC:     func_ff         <= rx_byte_in;
        mbw_pkg::POS_START_HI: start_ff[15:8]  <= rx_byte_in;
        mbw_pkg::POS_START_LO: start_ff[7:0]   <= rx_byte_in;
        mbw_pkg::POS_COUNT_HI: count_ff[15:8]  <= rx_byte_in;
        mbw_pkg::POS_COUNT_LO: count_ff[7:0]   <= rx_byte_in;
        mbw_pkg::POS_BCOUNT:   bcnt_ff         <= rx_byte_in;
        default:               hi_byte_ff      <= data_off[0] ? hi_byte_ff : rx_byte_in;
      endcase
    end
  end

  // Register values arrive upper byte first; staged until the check passes
  assign stage.we    = (state_ff == mbw_pkg::ST_RECV) && rx_valid_in && data_byte &&
                       data_off[0];
  assign stage.waddr = data_off[4:1];
  assign stage.wdata = {hi_byte_ff, rx_byte_in};
  assign stage.raddr = idx_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_ff <= mbw_pkg::ST_RECV;
      idx_ff   <= 4'h0;
      phase_ff <= 1'b0;
      exc_ff   <= 8'h00;
    end else begin
      case (state_ff)
        mbw_pkg::ST_RECV: begin
          idx_ff   <= 4'h0;
          phase_ff <= 1'b0;
          exc_ff   <= 8'h00;
          if (rx_frame_end_in && (pos_ff != 8'h00)) begin
            state_ff <= mbw_pkg::ST_CHECK;
          end
        end
        mbw_pkg::ST_CHECK: begin
          if (!frame_ok) begin
            state_ff <= mbw_pkg::ST_RECV;
          end else if (func_ff != mbw_pkg::FC_WRITE_MULTI) begin
            exc_ff   <= mbw_pkg::EXC_FUNC;
            state_ff <= mbw_pkg::ST_REPLY;
          end else if (!count_ok) begin
            exc_ff   <= mbw_pkg::EXC_VALUE;
            state_ff <= mbw_pkg::ST_REPLY;
          end else begin
            state_ff <= mbw_pkg::ST_WRITE;
          end
        end
        mbw_pkg::ST_WRITE: begin
          phase_ff <= ~phase_ff;
          if (phase_ff) begin
            // Out-of-map registers flag an exception but the walk goes on
            if (!reg_in_map) begin
              exc_ff <= mbw_pkg::EXC_ADDR;
            end
            idx_ff <= idx_ff + 4'h1;
            if (last_reg) begin
              state_ff <= mbw_pkg::ST_REPLY;
            end
          end
        end
        mbw_pkg::ST_REPLY: begin
          // A broadcast is obeyed silently
          if ((slave_ff == mbw_pkg::BCAST_ADDR) ||
              (tx_valid_ff && tx_ready_in && (txi_ff == tx_len - 4'h1))) begin
            state_ff <= mbw_pkg::ST_RECV;
          end
        end
        default: state_ff <= mbw_pkg::ST_RECV;
      endcase
    end
  end

  // Even register is the upper half of the datum, odd the lower half
  assign store.we    = commit ? (reg_addr[0] ? 2'b01 : 2'b10) : 2'b00;
  assign store.waddr = reg_addr[DATUM_AW:1];
  assign store.wdata = {stage.rdata, stage.rdata};
  assign store.raddr = drv_index_in;
  assign drv_data_out = store.rdata;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_strobe_ff <= 1'b0;
      wr_addr_ff   <= 16'h0000;
      wr_data_ff   <= 16'h0000;
    end else begin
      wr_strobe_ff <= commit;
      if (commit) begin
        wr_addr_ff <= reg_addr;
        wr_data_ff <= stage.rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply
  function automatic logic [7:0] reply_byte(input logic [3:0] i, input logic exc);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      4'h0:    b = slave_ff;
      4'h1:    b = exc ? (func_ff | mbw_pkg::EXC_FLAG) : func_ff;
      4'h2:    b = exc ? exc_ff : start_ff[15:8];
      4'h3:    b = start_ff[7:0];
      4'h4:    b = count_ff[15:8];
      4'h5:    b = count_ff[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      txi_ff      <= 4'h0;
      tx_crc_ff   <= mbw_pkg::CRC_INIT;
      tx_byte_ff  <= 8'h00;
      tx_valid_ff <= 1'b0;
    end else if ((state_ff != mbw_pkg::ST_REPLY) || (slave_ff == mbw_pkg::BCAST_ADDR)) begin
      txi_ff      <= 4'h0;
      tx_crc_ff   <= mbw_pkg::CRC_INIT;
      tx_valid_ff <= 1'b0;
    end else if (!tx_valid_ff) begin
      tx_valid_ff <= 1'b1;
      if (txi_ff == tx_len - 4'h2) begin
        tx_byte_ff <= tx_crc_ff[7:0];
      end else if (txi_ff == tx_len - 4'h1) begin
        tx_byte_ff <= tx_crc_ff[15:8];
      end else begin
        tx_byte_ff <= reply_byte(txi_ff, is_exc);
        tx_crc_ff  <= crc_step(tx_crc_ff, reply_byte(txi_ff, is_exc));
      end
    end else if (tx_ready_in) begin
      tx_valid_ff <= 1'b0;
      txi_ff      <= txi_ff + 4'h1;
    end
  end

  assign tx_byte_out   = tx_byte_ff;
  assign tx_valid_out  = tx_valid_ff;
  assign wr_strobe_out = wr_strobe_ff;
  assign wr_addr_out   = wr_addr_ff;
  assign wr_data_out   = wr_data_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic        seen_ff;
  logic [15:0] last_ff;
  logic [15:0] tx_res_ff;
  // Residue over every reply byte taken, check included, must end at zero
  always_ff @(posedge clk_in) begin
    if (reset_in || (state_ff != mbw_pkg::ST_REPLY)) begin
      tx_res_ff <= mbw_pkg::CRC_INIT;
    end else if (tx_valid_ff && tx_ready_in) begin
      tx_res_ff <= crc_step(tx_res_ff, tx_byte_ff);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || (state_ff == mbw_pkg::ST_RECV)) begin
      seen_ff <= 1'b0;
      last_ff <= 16'h0000;
    end else if (wr_strobe_ff) begin
      seen_ff <= 1'b1;
      last_ff <= wr_addr_ff;
    end
  end

  sequence s_good_query;
    (state_ff == mbw_pkg::ST_CHECK) && frame_ok && (func_ff == mbw_pkg::FC_WRITE_MULTI);
  endsequence
  sequence s_walk_start;
    (state_ff == mbw_pkg::ST_WRITE) && !phase_ff && (idx_ff == 4'h0);
  endsequence

  AST_FUNC_REJECT: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == mbw_pkg::ST_CHECK) && frame_ok && (func_ff != mbw_pkg::FC_WRITE_MULTI)
    |=> (state_ff == mbw_pkg::ST_REPLY) && (exc_ff == mbw_pkg::EXC_FUNC))
    else $error("Unsupported function not answered with exception 01");
  AST_COUNT_LIMIT: assert property (@(posedge clk_in) disable iff (reset_in)
    (store.we != 2'b00) |-> (count_ff <= mbw_pkg::MAX_REGS) && (idx_ff < count_ff[4:0]))
    else $error("Register committed beyond the request limit");
  AST_ASCENDING: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_strobe_ff && seen_ff |-> (wr_addr_ff == last_ff + 16'h0001))
    else $error("Registers not committed in ascending order");
  AST_KEEP_GOING: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == mbw_pkg::ST_WRITE) && phase_ff && !reg_in_map && !last_reg
    |=> (state_ff == mbw_pkg::ST_WRITE) ##1 (exc_ff == mbw_pkg::EXC_ADDR))
    else $error("Walk stopped or exception lost after a bad register");
  AST_WALK: assert property (@(posedge clk_in) disable iff (reset_in)
    s_good_query ##0 count_ok |=> s_walk_start ##1 phase_ff ##1
    (wr_strobe_ff == $past(reg_in_map)))
    else $error("Valid query did not start the register walk");
  AST_BAD_COUNT: assert property (@(posedge clk_in) disable iff (reset_in)
    s_good_query ##0 (!count_ok && (slave_ff != mbw_pkg::BCAST_ADDR))
    |=> (state_ff == mbw_pkg::ST_REPLY) [*2] ##0
    (exc_ff == mbw_pkg::EXC_VALUE) && (store.we == 2'b00))
    else $error("Bad count or byte count not rejected");
  AST_ACK_FUNC: assert property (@(posedge clk_in) disable iff (reset_in)
    tx_valid_ff && !is_exc && (txi_ff == 4'h1) |-> (tx_byte_ff == mbw_pkg::FC_WRITE_MULTI))
    else $error("Reply does not echo the function code");
  AST_CRC_LOW: assert property (@(posedge clk_in) disable iff (reset_in)
    tx_valid_ff && tx_ready_in && (txi_ff == tx_len - 4'h1) |=> (tx_res_ff == 16'h0000))
    else $error("Reply check bytes wrong or not sent low byte first");
  AST_HALF_LANE: assert property (@(posedge clk_in) disable iff (reset_in)
    (store.we != 2'b00) |-> (store.we == (reg_addr[0] ? 2'b01 : 2'b10)) ##1
    wr_strobe_ff && (wr_addr_ff[0] == $past(reg_addr[0])))
    else $error("Register half placed in the wrong lane");
endmodule

// *** tb/mbw_master.sv ***
// Bus master model for the multi-register write handler: sends queries, takes replies.
// Assumes the handler runs on clk_in and takes one byte per rx_valid pulse.
`timescale 1ns/1ps
module mbw_master (
  // Clock
  input  wire logic       clk_in,
  // Query stream toward the handler
  output logic      [7:0] rx_byte_out,
  output logic            rx_valid_out,
  output logic            rx_frame_end_out,
  // Reply stream from the handler
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out
);
  int         seed = 88914;
  logic [7:0] got[$];

  initial begin
    rx_byte_out      = 8'h00;
    rx_valid_out     = 1'b0;
    rx_frame_end_out = 1'b0;
    tx_ready_out     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply bytes taken where valid meets ready; ready stalls at random
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out)
      got.push_back(tx_byte_in);
    #1 tx_ready_out = ($random(seed) & 3) != 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reflected CRC-16, kept apart from the handler's own logic
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  // Whole frame then one end pulse; idle data line shows the inverse of the last byte
  task automatic send(input logic [7:0] q[$], input bit corrupt);
    logic [15:0] c;
    c = crc16(q);
    if (corrupt)
      c = ~c;
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    got.delete();
    foreach (q[i]) begin
      @(posedge clk_in);
      #1 rx_byte_out = q[i];
      rx_valid_out = 1'b1;
      @(posedge clk_in);
      #1 rx_valid_out = 1'b0;
      rx_byte_out = ~q[i];
    end
    @(posedge clk_in);
    #1 rx_frame_end_out = 1'b1;
    @(posedge clk_in);
    #1 rx_frame_end_out = 1'b0;
  endtask
endmodule

// *** tb/mbw_handler_tb.sv ***
// Self-checking bench for the multi-register write handler against a queue model.
// Assumes the master model in mbw_master.sv and the handler package constants.
`timescale 1ns/1ps
module mbw_handler_tb;
  localparam int         AW      = 11;
  localparam int         NREG    = 4096;
  localparam logic [7:0] MY_ADDR = 8'h04;

  logic          clk_in = 1'b0;
  logic          reset_in = 1'b1;
  logic [7:0]    rx_byte, tx_byte;
  logic          rx_valid, rx_frame_end, tx_valid_out, tx_ready;
  logic          wr_strobe_out;
  logic [15:0]   wr_addr_out, wr_data_out;
  logic [AW-1:0] drv_index_in;
  logic [31:0]   drv_data_out;
  int            mismatches = 0;
  int            tests_run = 0;
  int            seed = 88914;
  logic [15:0]   mem[int];
  logic [31:0]   wr_seen[$];
  logic [31:0]   wr_exp[$];
  logic [7:0]    tx_exp[$];

  always #12.5 clk_in = ~clk_in;

  mbw_handler #(.DATUM_AW(AW)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .slave_addr_in(MY_ADDR),
    .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_frame_end_in(rx_frame_end),
    .tx_byte_out(tx_byte), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready),
    .wr_strobe_out(wr_strobe_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
    .drv_index_in(drv_index_in), .drv_data_out(drv_data_out)
  );

  mbw_master u_master (
    .clk_in(clk_in), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
    .rx_frame_end_out(rx_frame_end), .tx_byte_in(tx_byte), .tx_valid_in(tx_valid_out),
    .tx_ready_out(tx_ready)
  );

  always @(posedge clk_in)
    if (!reset_in && wr_strobe_out === 1'b1)
      wr_seen.push_back({wr_addr_out, wr_data_out});

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Model of one query: expected commits and reply, then send and compare
  task automatic run(input logic [7:0] sa, input logic [7:0] fc, input logic [15:0] st,
                     input logic [15:0] cnt, input logic [7:0] bc, input logic [15:0] d[$],
                     input bit corrupt);
    logic [7:0]  q[$];
    logic [7:0]  r[$];
    logic [15:0] c;
    bit          bad;
    int          n;
    q = {sa, fc, st[15:8], st[7:0], cnt[15:8], cnt[7:0], bc};
    foreach (d[i]) begin
      q.push_back(d[i][15:8]);
      q.push_back(d[i][7:0]);
    end
    wr_exp.delete();
    tx_exp.delete();
    wr_seen.delete();
    bad = 1'b0;
    if (!corrupt && (sa == MY_ADDR || sa == mbw_pkg::BCAST_ADDR)) begin
      if (fc != mbw_pkg::FC_WRITE_MULTI)
        r = {sa, fc | mbw_pkg::EXC_FLAG, mbw_pkg::EXC_FUNC};
      else if (cnt == 0 || cnt > 16 || bc != 2 * cnt)
        r = {sa, fc | mbw_pkg::EXC_FLAG, mbw_pkg::EXC_VALUE};
      else begin
        for (int i = 0; i < cnt; i++) begin
          if (st + i < NREG) begin
            wr_exp.push_back({16'(st + i), d[i]});
            mem[st + i] = d[i];
          end else
            bad = 1'b1;
        end
        if (bad)
          r = {sa, fc | mbw_pkg::EXC_FLAG, mbw_pkg::EXC_ADDR};
        else
          r = {sa, fc, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
      end
      if (sa != mbw_pkg::BCAST_ADDR) begin
        c = u_master.crc16(r);
        tx_exp = {r, c[7:0], c[15:8]};
      end
    end
    u_master.send(q, corrupt);
    n = 0;
    while (n < 60 || u_master.got.size() < tx_exp.size()) begin
      @(posedge clk_in);
      n++;
      if (n > 400) begin
        check(32'h0, 32'h1);
        finish_test();
      end
    end
    repeat (4) @(posedge clk_in);
    check(32'(u_master.got.size()), 32'(tx_exp.size()));
    foreach (tx_exp[i])
      if (i < u_master.got.size())
        check({24'h0, u_master.got[i]}, {24'h0, tx_exp[i]});
    check(32'(wr_seen.size()), 32'(wr_exp.size()));
    foreach (wr_exp[i])
      if (i < wr_seen.size())
        check(wr_seen[i], wr_exp[i]);
  endtask

  // Read one datum back through the registered port
  task automatic check_datum(input int idx);
    #1 drv_index_in = idx[AW-1:0];
    @(posedge clk_in);
    @(posedge clk_in);
    #1 check(drv_data_out, {mem[2 * idx], mem[2 * idx + 1]});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] d[$];
    logic [15:0] none_q[$];
    int          st, cnt;
    drv_index_in = '0;
    repeat (4) @(posedge clk_in);
    #1 reset_in = 1'b0;
    check({30'h0, tx_valid_out, wr_strobe_out}, 32'h0);
    check({wr_addr_out, wr_data_out}, 32'h0);
    // Reference frame with its known reply check byte
    run(MY_ADDR, 8'h10, 16'h0600, 16'h0006, 8'h0c,
        {16'h0000, 16'h0002, 16'h0000, 16'h0032, 16'h0000, 16'h0096}, 1'b0);
    check({24'h0, u_master.got[7]}, 32'h0000_00d6);
    @(posedge clk_in);
    check_datum(32'h0301);
    check(drv_data_out, 32'h0000_0032);
    // Random runs of whole pairs, up to sixteen registers
    repeat (6) begin
      cnt = 2 * (1 + ($random(seed) & 7));
      st = $random(seed) & 32'h0fe0;
      d.delete();
      repeat (cnt) d.push_back(16'($random(seed)));
      run(MY_ADDR, 8'h10, st[15:0], cnt[15:0], 8'(2 * cnt), d, 1'b0);
      @(posedge clk_in);
      check_datum(st / 2 + cnt / 2 - 1);
    end
    d.delete();
    repeat (17) d.push_back(16'($random(seed)));
    // Sixteen registers crossing the end of the map: half written, then exception
    run(MY_ADDR, 8'h10, 16'h0ff8, 16'h0010, 8'h20, d[0:15], 1'b0);
    // Count, byte count and function faults write nothing
    run(MY_ADDR, 8'h10, 16'h0010, 16'h0011, 8'h22, d[0:16], 1'b0);
    run(MY_ADDR, 8'h10, 16'h0010, 16'h0003, 8'h04, d[0:1], 1'b0);
    run(MY_ADDR, 8'h10, 16'h0010, 16'h0000, 8'h00, none_q, 1'b0);
    run(MY_ADDR, 8'h03, 16'h0010, 16'h0002, 8'h04, d[0:1], 1'b0);
    // Bad check, other slave, broadcast
    run(MY_ADDR, 8'h10, 16'h0010, 16'h0002, 8'h04, d[0:1], 1'b1);
    run(8'h05, 8'h10, 16'h0010, 16'h0002, 8'h04, d[0:1], 1'b0);
    run(8'h00, 8'h10, 16'h0020, 16'h0002, 8'h04, d[2:3], 1'b0);
    @(posedge clk_in);
    check_datum(32'h0010);
    finish_test();
  end
endmodule
